// file: ltc_pkg.sv
// shared constants and types of the loop transmitter control register bank
package ltc_pkg;

  // write addresses of the serial control bus
  localparam logic [7:0] ADDR_GEN_RESET = 8'h01; // address only, no data
  localparam logic [7:0] ADDR_GEN_WR = 8'h02; // general control write
  localparam logic [7:0] ADDR_PHASE_WR = 8'h03; // loop_phase_setting
  localparam logic [7:0] ADDR_GAIN_WR = 8'h04; // path_gain_combined
  localparam logic [7:0] ADDR_FWD_WR = 8'h05; // forward_gain_alias
  localparam logic [7:0] ADDR_FB_WR = 8'h06; // feedback_gain_alias
  localparam logic [7:0] ADDR_AUX_WR = 8'h07; // auxiliary_measure_control

  // readback addresses
  localparam logic [7:0] ADDR_GEN_RD = 8'hf2; // general_control_readback
  localparam logic [7:0] ADDR_PHASE_RD = 8'hf3; // loop_phase_readback
  localparam logic [7:0] ADDR_GAIN_RD = 8'hf4; // path_gain_readback
  localparam logic [7:0] ADDR_FWD_RD = 8'hf5; // forward_gain_readback
  localparam logic [7:0] ADDR_FB_RD = 8'hf6; // feedback_gain_readback
  localparam logic [7:0] ADDR_AUX_RD = 8'hf7; // auxiliary readback

  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00; // all 8-bit registers
  localparam logic [15:0] RST_WORD = 16'h0000; // the 16-bit gain register

  // field positions
  localparam int PHASE_MSB = 7; // phase code, top of field
  localparam int PHASE_LSB = 3; // phase code, bottom of field
  localparam int FWD_MSB = 14; // forward attenuation code
  localparam int FWD_LSB = 11;
  localparam int FB_MSB = 5; // feedback attenuation code
  localparam int FB_LSB = 1;
  localparam int AUX_OFFSET_PWR = 7; // offset_meter_power
  localparam int AUX_OSC_PWR = 6; // instability detector power
  localparam int AUX_ENV_PWR = 5; // envelope_detector_power
  localparam int AUX_MEAS_SEL = 4; // measurement_output_pin route
  localparam int AUX_OSC_GAIN_HI = 3; // osc_detector_gain_hi
  localparam int AUX_OSC_GAIN_LO = 2; // osc_detector_gain_lo
  localparam int AUX_INSEL_HI = 1; // offset_input_select_hi
  localparam int AUX_INSEL_LO = 0; // offset_input_select_lo

  // serial framing
  localparam logic [2:0] LAST_BIT = 3'h7; // eighth bit of a byte
  localparam logic [4:0] RD_BITS_BYTE = 5'h08; // 8-bit readback length
  localparam logic [4:0] RD_BITS_WORD = 5'h10; // 16-bit readback length

  // what a completed write does to the store
  typedef enum logic [2:0] {
    LTC_T_NONE,
    LTC_T_RESET,
    LTC_T_GEN,
    LTC_T_PHASE,
    LTC_T_GAIN,
    LTC_T_FWD,
    LTC_T_FB,
    LTC_T_AUX
  } ltc_target_e;

  // one committed write, handed from the link to the system clock
  typedef struct packed {
    ltc_target_e target; // which register
    logic [15:0] data; // 16-bit value, 8-bit writes in [7:0]
  } ltc_write_s;

  // the whole register store
  typedef struct packed {
    logic [7:0] gen; // general control
    logic [7:0] phase; // loop_phase_setting
    logic [15:0] gain; // path_gain_combined
    logic [7:0] aux; // auxiliary_measure_control
  } ltc_store_s;

endpackage : ltc_pkg

// file: ltc_regbank.sv
// serial control port and register bank of the loop transmitter
`timescale 1ns/100ps
`default_nettype none

module ltc_regbank (
  input wire logic i_sys_clk, // system clock, 250 MHz
  input wire logic i_resetn, // async reset, active low
  input wire logic i_sclk, // serial clock from the host
  input wire logic i_csn, // serial select, active low
  input wire logic i_sdi, // serial command data in
  output logic o_sdo, // serial reply data out
  output logic o_sdo_oe, // reply pin driven when high
  output logic [7:0] o_general_ctrl, // general control bits
  output logic [4:0] o_phase_code, // loop phase, 11.25 deg steps
  output logic [3:0] o_fwd_atten, // forward attenuation, 2.5 dB steps
  output logic [4:0] o_fb_atten, // feedback attenuation code
  output logic o_offset_meter_power, // offset measuring circuits on
  output logic o_osc_detector_power, // instability detector on
  output logic o_envelope_detector_power, // envelope detector on
  output logic o_measurement_output_pin, // 1 envelope, 0 offset meter
  output logic o_osc_detector_gain_hi, // detector gain select, msb
  output logic o_osc_detector_gain_lo, // detector gain select, lsb
  output logic o_offset_input_select_hi, // amplifier input pair, msb
  output logic o_offset_input_select_lo // amplifier input pair, lsb
);

  // link frame states
  typedef enum logic [1:0] {
    LTC_ADDR, // collecting the address byte
    LTC_WDATA, // collecting write data
    LTC_RDATA, // shifting readback out
    LTC_IGNORE // rest of the frame is dropped
  } ltc_link_e;

  // applies one committed write to a store image; used in both domains
  function automatic ltc_pkg::ltc_store_s apply_write(
    input ltc_pkg::ltc_store_s cur,
    input ltc_pkg::ltc_write_s wr
  );
    ltc_pkg::ltc_store_s res;
    res = cur;
    unique case (wr.target)
      ltc_pkg::LTC_T_RESET: begin // every bit of every register
        res.gen = ltc_pkg::RST_BYTE;
        res.phase = ltc_pkg::RST_BYTE;
        res.gain = ltc_pkg::RST_WORD;
        res.aux = ltc_pkg::RST_BYTE;
      end
      ltc_pkg::LTC_T_GEN: res.gen = wr.data[7:0];
      // reserved bits stored as written so readback matches
      ltc_pkg::LTC_T_PHASE: res.phase = wr.data[7:0];
      ltc_pkg::LTC_T_GAIN: res.gain = wr.data;
      // the aliases hit the same storage as the 16-bit register
      ltc_pkg::LTC_T_FWD: res.gain[15:8] = wr.data[7:0];
      ltc_pkg::LTC_T_FB: res.gain[7:0] = wr.data[7:0];
      ltc_pkg::LTC_T_AUX: res.aux = wr.data[7:0];
      ltc_pkg::LTC_T_NONE: res = cur; // nothing to do
    endcase
    return res;
  endfunction : apply_write

  // link side ------------------------------------------------------------

  // frame reset: the host select going high ends every frame at once,
  // since the serial clock may stop without a final edge
  logic link_rst_n;
  assign link_rst_n = i_resetn & ~i_csn;

  ltc_link_e state_reg; // frame state
  ltc_link_e state_next;
  logic [7:0] shift_reg; // incoming bits, msb first
  logic [7:0] shift_next;
  logic [2:0] bit_cnt_reg; // bit position within a byte
  logic first_byte_reg; // 16-bit write still awaits its high byte
  logic first_byte_next;
  logic [7:0] hold_reg; // high byte of a 16-bit write
  logic [7:0] hold_next;
  ltc_pkg::ltc_target_e tgt_reg; // write target chosen by address
  ltc_pkg::ltc_target_e tgt_next;
  logic [15:0] rd_word_reg; // readback, msb goes out first
  logic [15:0] rd_word_next;
  logic [4:0] rd_left_reg; // readback bits still to send
  logic [4:0] rd_left_next;
  logic commit_fire; // a write or reset completes this edge
  ltc_pkg::ltc_write_s commit_req; // what completes
  ltc_pkg::ltc_write_s link_req_reg; // held for the system side
  logic link_tgl_reg; // flips once per committed write
  ltc_pkg::ltc_store_s mirror_reg; // link-side copy for readback
  logic sdo_reg; // reply bit, changes on falling edge
  logic sdo_oe_reg; // reply enable, changes on falling edge

  // byte just completed, with this edge's input bit
  logic [7:0] byte_now;
  logic byte_done;
  assign byte_now = {shift_reg[6:0], i_sdi};
  assign byte_done = (bit_cnt_reg == ltc_pkg::LAST_BIT);

  // frame decode: address byte first, then data or readback
  always_comb begin
    state_next = state_reg;
    shift_next = byte_now;
    first_byte_next = first_byte_reg;
    hold_next = hold_reg;
    tgt_next = tgt_reg;
    rd_word_next = rd_word_reg;
    rd_left_next = rd_left_reg;
    commit_fire = 1'b0;
    commit_req = '{target: ltc_pkg::LTC_T_NONE, data: 16'h0000};
    unique case (state_reg)
      LTC_ADDR: begin
        if (byte_done) begin
          state_next = LTC_WDATA; // only the write addresses 02 to 07 take data
          first_byte_next = 1'b0;
          unique case (byte_now)
            ltc_pkg::ADDR_GEN_RESET: begin // address only
              commit_fire = 1'b1;
              commit_req.target = ltc_pkg::LTC_T_RESET;
              state_next = LTC_IGNORE;
            end
            ltc_pkg::ADDR_GEN_WR: tgt_next = ltc_pkg::LTC_T_GEN;
            ltc_pkg::ADDR_PHASE_WR: tgt_next = ltc_pkg::LTC_T_PHASE;
            ltc_pkg::ADDR_GAIN_WR: begin // high byte comes first
              tgt_next = ltc_pkg::LTC_T_GAIN;
              first_byte_next = 1'b1;
            end
            ltc_pkg::ADDR_FWD_WR: tgt_next = ltc_pkg::LTC_T_FWD;
            ltc_pkg::ADDR_FB_WR: tgt_next = ltc_pkg::LTC_T_FB;
            ltc_pkg::ADDR_AUX_WR: tgt_next = ltc_pkg::LTC_T_AUX;
            // readbacks show the current store contents
            ltc_pkg::ADDR_GEN_RD: begin
              state_next = LTC_RDATA;
              rd_word_next = {mirror_reg.gen, 8'h00};
              rd_left_next = ltc_pkg::RD_BITS_BYTE;
            end
            ltc_pkg::ADDR_PHASE_RD: begin
              state_next = LTC_RDATA;
              rd_word_next = {mirror_reg.phase, 8'h00};
              rd_left_next = ltc_pkg::RD_BITS_BYTE;
            end
            ltc_pkg::ADDR_GAIN_RD: begin // the one 16-bit readback
              state_next = LTC_RDATA;
              rd_word_next = mirror_reg.gain;
              rd_left_next = ltc_pkg::RD_BITS_WORD;
            end
            ltc_pkg::ADDR_FWD_RD: begin
              state_next = LTC_RDATA;
              rd_word_next = {mirror_reg.gain[15:8], 8'h00};
              rd_left_next = ltc_pkg::RD_BITS_BYTE;
            end
            ltc_pkg::ADDR_FB_RD: begin
              state_next = LTC_RDATA;
              rd_word_next = {mirror_reg.gain[7:0], 8'h00};
              rd_left_next = ltc_pkg::RD_BITS_BYTE;
            end
            ltc_pkg::ADDR_AUX_RD: begin
              state_next = LTC_RDATA;
              rd_word_next = {mirror_reg.aux, 8'h00};
              rd_left_next = ltc_pkg::RD_BITS_BYTE;
            end
            default: state_next = LTC_IGNORE; // unknown address
          endcase
        end
      end
      LTC_WDATA: begin
        if (byte_done) begin
          if (first_byte_reg) begin // keep high byte, wait for low
            hold_next = byte_now;
            first_byte_next = 1'b0;
          end else begin
            commit_fire = 1'b1;
            commit_req.target = tgt_reg;
            commit_req.data = (tgt_reg == ltc_pkg::LTC_T_GAIN) ?
                              {hold_reg, byte_now} : {8'h00, byte_now};
            // trailing bytes are dropped rather than rewriting
            state_next = LTC_IGNORE;
          end
        end
      end
      LTC_RDATA: begin
        // one bit leaves per rising edge; host samples before the shift
        rd_word_next = {rd_word_reg[14:0], 1'b0};
        rd_left_next = rd_left_reg - 5'h01;
        if (rd_left_reg == 5'h01) begin
          state_next = LTC_IGNORE;
        end
      end
      LTC_IGNORE: state_next = LTC_IGNORE; // wait for select to rise
    endcase
  end

  // frame state, restarted by every select pulse
  always_ff @(posedge i_sclk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      state_reg <= LTC_ADDR;
      shift_reg <= 8'h00;
      bit_cnt_reg <= 3'h0;
      first_byte_reg <= 1'b0;
      hold_reg <= 8'h00;
      tgt_reg <= ltc_pkg::LTC_T_NONE;
      rd_word_reg <= 16'h0000;
      rd_left_reg <= 5'h00;
    end else begin
      state_reg <= state_next;
      shift_reg <= shift_next; // data sampled on rising edge
      bit_cnt_reg <= bit_cnt_reg + 3'h1; // wraps every eight bits
      first_byte_reg <= first_byte_next;
      hold_reg <= hold_next;
      tgt_reg <= tgt_next;
      rd_word_reg <= rd_word_next;
      rd_left_reg <= rd_left_next;
    end
  end

  // committed writes and the readback mirror; of the two resets only the main one
  // clears these, a frame ending must not lose them
  always_ff @(posedge i_sclk or negedge i_resetn) begin
    if (!i_resetn) begin
      link_req_reg <= '{target: ltc_pkg::LTC_T_NONE, data: 16'h0000};
      link_tgl_reg <= 1'b0;
      mirror_reg <= '0; // pin and power-on reset
    end else if (commit_fire) begin
      link_req_reg <= commit_req; // stable until the next commit
      link_tgl_reg <= ~link_tgl_reg;
      mirror_reg <= apply_write(mirror_reg, commit_req);
    end
  end

  // reply pin, updated on falling edges so it is settled at the
  // rising edge where the host samples it
  always_ff @(negedge i_sclk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      sdo_reg <= 1'b0;
      sdo_oe_reg <= 1'b0;
    end else begin
      sdo_reg <= rd_word_reg[15];
      sdo_oe_reg <= (state_reg == LTC_RDATA);
    end
  end

  assign o_sdo = sdo_reg;
  assign o_sdo_oe = sdo_oe_reg;

  // system side ----------------------------------------------------------

  // toggle crossing; the request word is held steady for at least
  // eight serial clocks, far longer than the two-stage sync takes
  logic tgl_meta_reg; // first stage, read only by the second
  logic tgl_sync_reg; // second stage
  logic tgl_seen_reg; // previous synced value
  logic sys_fire; // one-cycle pulse per committed write

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      tgl_meta_reg <= 1'b0;
      tgl_sync_reg <= 1'b0;
      tgl_seen_reg <= 1'b0;
    end else begin
      tgl_meta_reg <= link_tgl_reg;
      tgl_sync_reg <= tgl_meta_reg;
      tgl_seen_reg <= tgl_sync_reg;
    end
  end

  assign sys_fire = tgl_sync_reg ^ tgl_seen_reg;

  // the store that drives the analogue controls
  ltc_pkg::ltc_store_s store_reg;

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      store_reg <= '0; // everything cleared, power save
    end else if (sys_fire) begin
      store_reg <= apply_write(store_reg, link_req_reg);
    end
  end

  // control outputs straight from the stored fields
  assign o_general_ctrl = store_reg.gen;
  assign o_phase_code =
    store_reg.phase[ltc_pkg::PHASE_MSB:ltc_pkg::PHASE_LSB];
  assign o_fwd_atten =
    store_reg.gain[ltc_pkg::FWD_MSB:ltc_pkg::FWD_LSB];
  // code counts down as attenuation rises; 0 is the most attenuation
  assign o_fb_atten =
    store_reg.gain[ltc_pkg::FB_MSB:ltc_pkg::FB_LSB];
  assign o_offset_meter_power =
    store_reg.aux[ltc_pkg::AUX_OFFSET_PWR];
  assign o_osc_detector_power =
    store_reg.aux[ltc_pkg::AUX_OSC_PWR];
  assign o_envelope_detector_power =
    store_reg.aux[ltc_pkg::AUX_ENV_PWR];
  assign o_measurement_output_pin =
    store_reg.aux[ltc_pkg::AUX_MEAS_SEL];
  assign o_osc_detector_gain_hi =
    store_reg.aux[ltc_pkg::AUX_OSC_GAIN_HI];
  assign o_osc_detector_gain_lo =
    store_reg.aux[ltc_pkg::AUX_OSC_GAIN_LO];
  assign o_offset_input_select_hi =
    store_reg.aux[ltc_pkg::AUX_INSEL_HI];
  assign o_offset_input_select_lo =
    store_reg.aux[ltc_pkg::AUX_INSEL_LO];

endmodule : ltc_regbank

`default_nettype wire

// file: ltc_regbank_chk.sv
// port assertions for the loop transmitter register bank
`timescale 1ns/100ps
`default_nettype none
module ltc_regbank_chk (
  input wire logic i_sys_clk, // sys clock
  input wire logic i_resetn, // reset
  input wire logic i_sclk, // link clock
  input wire logic i_csn, // frame select
  input wire logic i_sdi, // data in
  input wire logic o_sdo, // reply bit
  input wire logic o_sdo_oe, // reply enable
  input wire logic [4:0] o_phase_code, // phase
  input wire logic [3:0] o_fwd_atten, // fwd
  input wire logic [4:0] o_fb_atten, // fb
  input wire logic o_offset_meter_power, // b7
  input wire logic o_osc_detector_power, // b6
  input wire logic o_envelope_detector_power, // b5
  input wire logic o_measurement_output_pin, // b4
  input wire logic o_osc_detector_gain_hi, // b3
  input wire logic o_osc_detector_gain_lo, // b2
  input wire logic o_offset_input_select_hi, // b1
  input wire logic o_offset_input_select_lo // b0
);
  logic [4:0] rc; // rises seen in this frame
  logic [7:0] ad; // address byte of this frame
  logic [15:0] dsr; // last bits shifted in, kept after the frame
  wire [7:0] aux = {o_offset_meter_power, o_osc_detector_power,
    o_envelope_detector_power, o_measurement_output_pin,
    o_osc_detector_gain_hi, o_osc_detector_gain_lo,
    o_offset_input_select_hi, o_offset_input_select_lo};
  // reserved bits assumed zero, as a legal host leaves them
  wire [15:0] gw = {1'b0, o_fwd_atten, 5'h00, o_fb_atten, 1'b0};
  wire [21:0] outs = {o_phase_code, o_fwd_atten, o_fb_atten, aux};
  wire gr = (rc == 5'h08) && (ad == 8'h01); // reset command seen
  wire w03 = (rc == 5'h10) && (ad == 8'h03); // phase write seen
  // frame state clears on select high so a cut frame cannot leak
  always_ff @(posedge i_sclk or posedge i_csn or negedge i_resetn) begin
    if (!i_resetn || i_csn) begin
      rc <= 5'h00;
      ad <= 8'h00;
    end else begin
      if (rc != 5'h1f) rc <= rc + 5'h01;
      if (rc < 5'h08) ad <= {ad[6:0], i_sdi};
    end
  end
  // data history is not cleared by select, read after the frame
  always_ff @(posedge i_sclk or negedge i_resetn) begin
    if (!i_resetn) dsr <= 16'h0000;
    else dsr <= {dsr[14:0], i_sdi};
  end
  property p_oe_addr; @(posedge i_sclk) disable iff (!i_resetn)
    o_sdo_oe |-> rc >= 5'h08 && ad[7:4] == 4'hf; endproperty
  a_oe_addr: assert property (p_oe_addr) else $error("early oe");
  property p_oe_frame; @(posedge i_sys_clk) disable iff (!i_resetn)
    o_sdo_oe |-> !i_csn; endproperty
  a_oe_frame: assert property (p_oe_frame) else $error("oe idle");
  property p_aux_rd; @(posedge i_sclk) disable iff (!i_resetn)
    ad == 8'hf7 && rc >= 5'h08 && rc < 5'h10 |-> o_sdo == aux[5'h0f - rc];
  endproperty
  a_aux_rd: assert property (p_aux_rd) else $error("aux read");
  property p_gain_rd; @(posedge i_sclk) disable iff (!i_resetn)
    ad == 8'hf4 && rc >= 5'h08 && rc < 5'h18 |-> o_sdo == gw[5'h17 - rc];
  endproperty
  a_gain_rd: assert property (p_gain_rd) else $error("gain read");
  property p_rst_clr; @(posedge i_sys_clk) disable iff (!i_resetn)
    $rose(i_resetn) |-> outs == 22'h0; endproperty
  a_rst_clr: assert property (p_rst_clr) else $error("rst val");
  property p_gen_rst; @(posedge i_sys_clk) disable iff (!i_resetn)
    $rose(i_csn) && $past(gr) |-> ##[0:8] outs == 22'h0; endproperty
  a_gen_rst: assert property (p_gen_rst) else $error("cmd rst");
  property p_idle; @(posedge i_sys_clk) disable iff (!i_resetn)
    i_csn [*8] |-> $stable(outs); endproperty
  a_idle: assert property (p_idle) else $error("idle change");
  property p_phase_wr; @(posedge i_sys_clk) disable iff (!i_resetn)
    $rose(i_csn) && $past(w03) |-> o_phase_code == dsr[7:3]; endproperty
  a_phase_wr: assert property (p_phase_wr) else $error("phase");
endmodule : ltc_regbank_chk
bind ltc_regbank ltc_regbank_chk ltc_regbank_chk_i (
  .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_sclk(i_sclk),
  .i_csn(i_csn), .i_sdi(i_sdi), .o_sdo(o_sdo), .o_sdo_oe(o_sdo_oe),
  .o_phase_code(o_phase_code), .o_fwd_atten(o_fwd_atten),
  .o_fb_atten(o_fb_atten), .o_offset_meter_power(o_offset_meter_power),
  .o_osc_detector_power(o_osc_detector_power),
  .o_envelope_detector_power(o_envelope_detector_power),
  .o_measurement_output_pin(o_measurement_output_pin),
  .o_osc_detector_gain_hi(o_osc_detector_gain_hi),
  .o_osc_detector_gain_lo(o_osc_detector_gain_lo),
  .o_offset_input_select_hi(o_offset_input_select_hi),
  .o_offset_input_select_lo(o_offset_input_select_lo));
`default_nettype wire

// file: ltc_host_model.sv
// host model: bit-banged master of the serial control link
`timescale 1ns/100ps
`default_nettype none
module ltc_host_model (
  output logic o_sclk, // link clock, still between frames
  output logic o_csn, // frame select, active low
  output logic o_sdi, // command data
  input wire logic i_sdo, // reply data
  input wire logic i_sdo_oe // reply enable, line released when low
);
  localparam realtime HALF = 62.5; // half of the 125 ns period
  initial begin
    o_sclk = 1'b0;
    o_csn = 1'b1;
    o_sdi = 1'b0;
  end
  // one frame; d comes back as actually sent
  task automatic xfer(input logic [7:0] a, inout logic [15:0] d,
      input int nw, input int nr, output logic [15:0] q);
    logic b;
    q = 16'h0000;
    b = o_sdi;
    case (a)
      8'h03: d = d & 16'h00f8; // reserved phase bits low
      8'h04: d = d & 16'h783e; // reserved gain bits low
      8'h05: d = d & 16'h0078;
      8'h06: d = d & 16'h003e;
      default: ; // other bytes go as given
    endcase
    #1.3 o_csn = 1'b0;
    for (int i = 0; i < 8 + nw + nr; i++) begin
      if (i < 8) b = a[7 - i]; // address first, msb first
      else if (i < 8 + nw) b = d[nw + 7 - i];
      else b = ~b; // line toggles while only listening
      o_sdi = b;
      #HALF o_sclk = 1'b1;
      // taken on rise; a released reply line shows the inverse bit
      if (i >= 8 + nw) q = {q[14:0], i_sdo_oe ? i_sdo : ~i_sdo};
      #HALF o_sclk = 1'b0;
    end
    #HALF o_csn = 1'b1;
    o_sdi = ~o_sdi; // released line must not look stale
    #(2 * HALF);
  endtask : xfer
endmodule : ltc_host_model
`default_nettype wire

// file: ltc_regbank_tb.sv
// self-checking bench for the loop transmitter register bank
`timescale 1ns/100ps
`default_nettype none
module ltc_regbank_tb;
  logic clk, rstn; // system side
  wire sclk, csn, sdi, sdo, oe; // link lines
  wire [7:0] gen_o, aux_o; // general and aux outputs
  wire [4:0] ph_o, fb_o; // phase and feedback codes
  wire [3:0] fw_o; // forward code
  logic [15:0] q, dv; // reply word, scratch data
  logic [31:0] seed, r; // xorshift state and draw
  int failures, checks_done, cyc; // bookkeeping
  int m_gen, m_ph, m_gain, m_aux; // reference registers
  logic [7:0] wtb [10] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07,
    8'h08, 8'h00, 8'h09, 8'hf3}; // mapped, unmapped, read-only
  ltc_host_model ltc_host_model_i (.o_sclk(sclk), .o_csn(csn),
    .o_sdi(sdi), .i_sdo(sdo), .i_sdo_oe(oe));
  ltc_regbank ltc_regbank_i (.i_sys_clk(clk), .i_resetn(rstn),
    .i_sclk(sclk), .i_csn(csn), .i_sdi(sdi), .o_sdo(sdo), .o_sdo_oe(oe),
    .o_general_ctrl(gen_o), .o_phase_code(ph_o), .o_fwd_atten(fw_o),
    .o_fb_atten(fb_o), .o_offset_meter_power(aux_o[7]),
    .o_osc_detector_power(aux_o[6]), .o_envelope_detector_power(aux_o[5]),
    .o_measurement_output_pin(aux_o[4]), .o_osc_detector_gain_hi(aux_o[3]),
    .o_osc_detector_gain_lo(aux_o[2]), .o_offset_input_select_hi(aux_o[1]),
    .o_offset_input_select_lo(aux_o[0]));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // cut a hang short, whole run is about 52k cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      failures++;
      wrap_up();
    end
  end
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  task automatic clr();
    m_gen = 0;
    m_ph = 0;
    m_gain = 0;
    m_aux = 0;
  endtask : clr
  task automatic cmp_out();
    logic [29:0] e;
    e = {m_gen[7:0], m_ph[7:3], m_gain[14:11], m_gain[5:1], m_aux[7:0]};
    checks_done++;
    if ({gen_o, ph_o, fw_o, fb_o, aux_o} !== e) begin
      failures++;
      $display("[FAIL] %0t out %h exp %h", $time,
        {gen_o, ph_o, fw_o, fb_o, aux_o}, e);
    end
  endtask : cmp_out
  task automatic cmp_rd(input logic [15:0] g, input logic [15:0] e);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %0t read %h exp %h", $time, g, e);
    end
  endtask : cmp_rd
  // write frame, then model update and output compare
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    ltc_host_model_i.xfer(a, d, (a == 8'h04) ? 16 : (a == 8'h01) ? 0 : 8,
      0, q);
    case (a)
      8'h01: clr();
      8'h02: m_gen = d[7:0];
      8'h03: m_ph = d[7:0];
      8'h04: m_gain = d;
      8'h05: m_gain[15:8] = d[7:0];
      8'h06: m_gain[7:0] = d[7:0];
      8'h07: m_aux = d[7:0];
      default: ; // unmapped: store untouched
    endcase
    @(negedge clk);
    cmp_out();
  endtask : wr
  task automatic rd(input logic [7:0] a);
    int v;
    logic [15:0] e;
    e = 16'h0000;
    case (a)
      8'hf2: v = m_gen;
      8'hf3: v = m_ph;
      8'hf4: v = m_gain;
      8'hf5: v = m_gain >> 8;
      8'hf6: v = m_gain & 255;
      default: v = m_aux;
    endcase
    ltc_host_model_i.xfer(a, e, 0, (a == 8'hf4) ? 16 : 8, q);
    cmp_rd(q, v[15:0]);
  endtask : rd
  task automatic wrap_up();
    if (failures == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up
  // main sequence
  initial begin
    rstn = 1'b0;
    seed = 32'ha046;
    clr();
    repeat (20) @(negedge clk);
    rstn = 1'b1;
    cmp_out();
    for (int k = 0; k < 6; k++) rd(8'hf2 + k[7:0]);
    for (int k = 0; k < 4; k++) begin
      wr(8'h07, {8'h00, {4{k[1:0]}}});
      rd(8'hf7);
    end
    wr(8'h02, 16'h00a5);
    rd(8'hf2);
    wr(8'h03, 16'h00f8);
    rd(8'hf3);
    wr(8'h04, 16'h603a);
    wr(8'h05, 16'h00ff);
    rd(8'hf4);
    rd(8'hf5);
    wr(8'h06, 16'h00ff);
    rd(8'hf4);
    rd(8'hf6);
    // gain write cut after one byte must be dropped
    dv = 16'h00ff;
    ltc_host_model_i.xfer(8'h04, dv, 8, 0, q);
    @(negedge clk);
    cmp_out();
    repeat (30) begin
      r = xs();
      wr(wtb[r % 10], r[31:16]);
      rd(8'hf2 + r[7:0] % 8'h06);
    end
    wr(8'h01, 16'h0000);
    rd(8'hf4);
    wr(8'h07, 16'h00ff);
    @(negedge clk) rstn = 1'b0;
    repeat (3) @(negedge clk);
    rstn = 1'b1;
    clr();
    cmp_out();
    rd(8'hf7);
    wrap_up();
  end
endmodule : ltc_regbank_tb
`default_nettype wire
